// ==== hw/vst_pkg.sv ====
package vst_pkg;

  // ==========================================================================
  // Timing figures, printed units
  localparam int CLAMP_START_NS = 5500;
  localparam int CLAMP_LEN_NS = 2500;
  localparam int OFFC_START_NS = 350;
  localparam int OFFC_LEN_NS = 140;
  localparam int NTSC_SW_MIN_NS = 2800;
  localparam int NTSC_SW_MAX_NS = 5300;
  localparam int PAL_SW_MIN_NS = 3300;
  localparam int PAL_SW_MAX_NS = 5400;
  // Reference clock in kHz per standard
  localparam int NTSC_REF_KHZ = 14318;
  localparam int PAL_REF_KHZ = 17734;

  // ==========================================================================
  // Cycle counts per standard (least times round up, longest round down)
  function automatic int cyc_up(input int ns, input int khz);
    return (ns * khz + 999999) / 1000000;
  endfunction : cyc_up
  function automatic int cyc_dn(input int ns, input int khz);
    return (ns * khz) / 1000000;
  endfunction : cyc_dn

  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] NTSC_SW_MIN = CNT_W'(cyc_up(NTSC_SW_MIN_NS, NTSC_REF_KHZ));
  localparam logic [CNT_W-1:0] NTSC_SW_MAX = CNT_W'(cyc_dn(NTSC_SW_MAX_NS, NTSC_REF_KHZ));
  localparam logic [CNT_W-1:0] PAL_SW_MIN = CNT_W'(cyc_up(PAL_SW_MIN_NS, PAL_REF_KHZ));
  localparam logic [CNT_W-1:0] PAL_SW_MAX = CNT_W'(cyc_dn(PAL_SW_MAX_NS, PAL_REF_KHZ));
  localparam logic [CNT_W-1:0] NTSC_CLAMP_ON = CNT_W'(cyc_up(CLAMP_START_NS, NTSC_REF_KHZ));
  localparam logic [CNT_W-1:0] NTSC_CLAMP_OFF = CNT_W'(cyc_up(CLAMP_START_NS + CLAMP_LEN_NS, NTSC_REF_KHZ));
  localparam logic [CNT_W-1:0] PAL_CLAMP_ON = CNT_W'(cyc_up(CLAMP_START_NS, PAL_REF_KHZ));
  localparam logic [CNT_W-1:0] PAL_CLAMP_OFF = CNT_W'(cyc_up(CLAMP_START_NS + CLAMP_LEN_NS, PAL_REF_KHZ));
  localparam logic [CNT_W-1:0] NTSC_OFFC_ON = CNT_W'(cyc_up(OFFC_START_NS, NTSC_REF_KHZ));
  localparam logic [CNT_W-1:0] NTSC_OFFC_OFF = CNT_W'(cyc_up(OFFC_START_NS + OFFC_LEN_NS, NTSC_REF_KHZ));
  localparam logic [CNT_W-1:0] PAL_OFFC_ON = CNT_W'(cyc_up(OFFC_START_NS, PAL_REF_KHZ));
  localparam logic [CNT_W-1:0] PAL_OFFC_OFF = CNT_W'(cyc_up(OFFC_START_NS + OFFC_LEN_NS, PAL_REF_KHZ));
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;

  // ==========================================================================
  typedef enum logic [1:0] {
    VST_IDLE,
    VST_MEASURE,
    VST_LINE
  } vst_phase_t;

  typedef struct packed {
    logic burst_flag;
    logic clamp_window;
    logic offset_cancel;
    logic v_phase;
    logic vblank_mode;
    logic retune_request;
  } vst_timing_t;

  typedef struct packed {
    logic [2:0] hs_sync;
    logic [2:0] vs_sync;
    logic hs_stable;
    logic vs_stable;
    logic half_en;
    logic cs_latched;
    vst_phase_t phase;
    logic [CNT_W-1:0] width_cnt;
    logic [CNT_W-1:0] edge_cnt;
    logic line_ok;
    vst_timing_t out;
  } vst_state_t;

endpackage : vst_pkg

// ==== hw/vst_sync_timing.sv ====
`timescale 1ns/100ps
module vst_sync_timing (
  input wire logic clk,
  input wire logic srst,
  input wire logic standard_select,
  input wire logic power_enable,
  input wire logic hsync_in,
  input wire logic vsync_in,
  output logic combined_sync,
  output logic chip_active,
  output vst_pkg::vst_timing_t timing
);

  // ==========================================================================
  // State
  vst_pkg::vst_state_t st;
  vst_pkg::vst_state_t next_st;

  logic [vst_pkg::CNT_W-1:0] sw_min;
  logic [vst_pkg::CNT_W-1:0] sw_max;
  logic [vst_pkg::CNT_W-1:0] clamp_on;
  logic [vst_pkg::CNT_W-1:0] clamp_off;
  logic [vst_pkg::CNT_W-1:0] offc_on;
  logic [vst_pkg::CNT_W-1:0] offc_off;
  logic cs_raw;
  logic cs_fall;
  logic cs_rise;
  logic in_window;
  logic hs_agree;
  logic vs_agree;
  logic width_ok;
  logic edge_full;
  logic width_full;
  logic phase_busy;
  logic clamp_hit_on;
  logic clamp_hit_off;
  logic offc_hit_on;
  logic offc_hit_off;

  // ==========================================================================
  // Standard selection
  always_comb begin
    if (standard_select) begin
      sw_min = vst_pkg::NTSC_SW_MIN;
      sw_max = vst_pkg::NTSC_SW_MAX;
      clamp_on = vst_pkg::NTSC_CLAMP_ON;
      clamp_off = vst_pkg::NTSC_CLAMP_OFF;
      offc_on = vst_pkg::NTSC_OFFC_ON;
      offc_off = vst_pkg::NTSC_OFFC_OFF;
    end else begin
      sw_min = vst_pkg::PAL_SW_MIN;
      sw_max = vst_pkg::PAL_SW_MAX;
      clamp_on = vst_pkg::PAL_CLAMP_ON;
      clamp_off = vst_pkg::PAL_CLAMP_OFF;
      offc_on = vst_pkg::PAL_OFFC_ON;
      offc_off = vst_pkg::PAL_OFFC_OFF;
    end
  end

  // ==========================================================================
  // Window decode
  // A pin change counts only once the second and third stages agree
  assign hs_agree = (st.hs_sync[2] == st.hs_sync[1]);
  assign vs_agree = (st.vs_sync[2] == st.vs_sync[1]);
  // Both counters saturate, so a lost edge can never reopen a window late
  assign edge_full = (st.edge_cnt == vst_pkg::CNT_MAX);
  assign width_full = (st.width_cnt == vst_pkg::CNT_MAX);
  // Half-rate latch quantises width to two clocks; limits are rounded inward
  assign width_ok = (st.width_cnt >= sw_min) && (st.width_cnt <= sw_max);
  assign phase_busy = (st.phase != vst_pkg::VST_IDLE);
  assign clamp_hit_on = phase_busy && (st.edge_cnt == clamp_on);
  assign clamp_hit_off = (st.edge_cnt == clamp_off);
  assign offc_hit_on = phase_busy && (st.edge_cnt == offc_on);
  assign offc_hit_off = (st.edge_cnt == offc_off);

  // ==========================================================================
  // Next state
  always_comb begin
    next_st = st;
    cs_raw = 1'b0;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    in_window = 1'b0;
    // Pins cross in; stage 0 feeds only stage 1
    next_st.hs_sync = {st.hs_sync[1:0], hsync_in};
    next_st.vs_sync = {st.vs_sync[1:0], vsync_in};
    if (hs_agree) begin
      next_st.hs_stable = st.hs_sync[2];
    end
    if (vs_agree) begin
      next_st.vs_stable = st.vs_sync[2];
    end
    next_st.half_en = ~st.half_en;
    cs_raw = ~(st.hs_stable ^ st.vs_stable);
    if (st.half_en) begin
      next_st.cs_latched = cs_raw;
      cs_fall = st.cs_latched & ~cs_raw;
      cs_rise = ~st.cs_latched & cs_raw;
    end
    next_st.out.retune_request = 1'b0;
    if (!edge_full) begin
      next_st.edge_cnt = st.edge_cnt + 1'b1;
    end
    if (!width_full) begin
      next_st.width_cnt = st.width_cnt + 1'b1;
    end
    if (!power_enable) begin
      next_st.phase = vst_pkg::VST_IDLE;
      next_st.out.burst_flag = 1'b0;
      next_st.out.clamp_window = 1'b0;
      next_st.out.offset_cancel = 1'b0;
      next_st.line_ok = 1'b0;
      // Counts parked so a stale measurement cannot finish after enable
      next_st.width_cnt = vst_pkg::CNT_MAX;
      next_st.edge_cnt = vst_pkg::CNT_MAX;
    end else begin
      if (cs_fall) begin
        next_st.phase = vst_pkg::VST_MEASURE;
        next_st.width_cnt = '0;
        next_st.edge_cnt = '0;
        next_st.line_ok = 1'b0;
        next_st.out.burst_flag = 1'b0;
        next_st.out.clamp_window = 1'b0;
        if (!standard_select) begin
          next_st.out.v_phase = ~st.out.v_phase;
        end
      end else begin
        case (st.phase)
          vst_pkg::VST_IDLE: begin
            next_st.line_ok = 1'b0;
          end
          vst_pkg::VST_MEASURE: begin
            if (cs_rise) begin
              next_st.phase = vst_pkg::VST_LINE;
              in_window = width_ok;
              next_st.line_ok = in_window;
              next_st.out.vblank_mode = ~in_window;
              if (!in_window) begin
                next_st.out.retune_request = 1'b1;
              end
            end
          end
          vst_pkg::VST_LINE: begin
            // Holds until the next falling edge; the counter carries the windows
            next_st.phase = vst_pkg::VST_LINE;
          end
          default: begin
            // Unused code falls back to idle and waits for an edge
            next_st.phase = vst_pkg::VST_IDLE;
          end
        endcase
        // Gating on line_ok keeps burst off for broad and equalising pulses
        if (clamp_hit_on && (st.line_ok || next_st.line_ok)) begin
          next_st.out.burst_flag = 1'b1;
          next_st.out.clamp_window = 1'b1;
        end else if (clamp_hit_off) begin
          next_st.out.burst_flag = 1'b0;
          next_st.out.clamp_window = 1'b0;
        end
      end
      // Offset window runs every line, broad pulses included
      if (cs_fall) begin
        next_st.out.offset_cancel = 1'b0;
      end else if (offc_hit_on) begin
        next_st.out.offset_cancel = 1'b1;
      end else if (offc_hit_off) begin
        next_st.out.offset_cancel = 1'b0;
      end
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk) begin
    if (srst) begin
      // Stages start at the pins' idle high, so no false edge follows reset
      st.hs_sync <= 3'h7;
      st.vs_sync <= 3'h7;
      st.hs_stable <= 1'b1;
      st.vs_stable <= 1'b1;
      st.half_en <= 1'b0;
      st.cs_latched <= 1'b1;
      st.phase <= vst_pkg::VST_IDLE;
      st.width_cnt <= vst_pkg::CNT_MAX;
      st.edge_cnt <= vst_pkg::CNT_MAX;
      st.line_ok <= 1'b0;
      st.out.burst_flag <= 1'b0;
      st.out.clamp_window <= 1'b0;
      st.out.offset_cancel <= 1'b0;
      st.out.v_phase <= 1'b0;
      st.out.vblank_mode <= 1'b0;
      st.out.retune_request <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  // Windows leave flip-flops directly, so no decode glitch reaches the pins
  assign combined_sync = st.cs_latched;
  assign chip_active = power_enable;
  assign timing = st.out;

endmodule : vst_sync_timing

// ==== verification/vst_sync_timing_checker.sv ====
`timescale 1ns/100ps
// ====================
// Port checks
module vst_sync_timing_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic standard_select,
  input wire logic power_enable,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic combined_sync,
  input wire logic chip_active,
  input wire vst_pkg::vst_timing_t timing
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_clamp_burst: assert property (timing.clamp_window == timing.burst_flag)
    else $error("clamp differs");
  a_chip_follow: assert property (chip_active == power_enable)
    else $error("active differs");
  a_off_idle: assert property (!power_enable ##1 !power_enable |-> !timing.burst_flag && !timing.offset_cancel)
    else $error("window while off");
  a_sync_half: assert property ($changed(combined_sync) |=> $stable(combined_sync))
    else $error("sync not half rate");
  // Power drop may cut a window short, so it is excused
  a_offc_len: assert property (disable iff (srst || !power_enable)
    $rose(timing.offset_cancel) |=> timing.offset_cancel ##1 !timing.offset_cancel) else $error("offset length");
  a_burst_len: assert property (disable iff (srst || !power_enable)
    $rose(timing.burst_flag) |-> timing.burst_flag [*8] ##[20:40] !timing.burst_flag) else $error("burst length");
  a_burst_line: assert property ($rose(timing.burst_flag) |-> !timing.vblank_mode)
    else $error("burst in blanking");
  a_retune_vb: assert property (timing.retune_request |-> ##[0:1] timing.vblank_mode)
    else $error("retune outside blanking");
  a_retune_one: assert property (timing.retune_request |=> !timing.retune_request)
    else $error("retune too long");
endmodule : vst_sync_timing_checker

bind vst_sync_timing vst_sync_timing_checker u_chk (.clk(clk), .srst(srst),
  .standard_select(standard_select), .power_enable(power_enable), .hsync_in(hsync_in), .vsync_in(vsync_in),
  .combined_sync(combined_sync), .chip_active(chip_active), .timing(timing));

// ==== verification/vst_source.sv ====
`timescale 1ns/100ps
// ====================
// Sync source model
module vst_source (
  input wire logic clk,
  output logic hsync_in,
  output logic vsync_in,
  output logic colour_black
);
  initial begin
    hsync_in = 1'h1;
    vsync_in = 1'h1;
    colour_black = 1'h0;
  end
  // One sync pulse, then a gap long enough for every window to close
  task automatic pulse(input int w, input logic comp);
    @(negedge clk);
    colour_black = 1'h1;
    if (comp) begin
      hsync_in = 1'h0;
    end else begin
      vsync_in = 1'h0;
    end
    repeat (w) @(negedge clk);
    hsync_in = 1'h1;
    vsync_in = 1'h1;
    // Black held well past the latest clamp end, then active video returns
    repeat (150) @(negedge clk);
    colour_black = 1'h0;
    repeat (50) @(negedge clk);
  endtask : pulse
endmodule : vst_source

// ==== verification/vst_sync_timing_tb.sv ====
`timescale 1ns/100ps
// ====================
// Bench
module vst_sync_timing_tb;
  logic clk, srst, standard_select, power_enable, hsync_in, vsync_in, combined_sync, chip_active, v0, colour_black;
  vst_pkg::vst_timing_t timing;
  int bad_count, total_checks, n_burst, n_off, n_low, n_ret, n_dirty;

  vst_sync_timing DUT (.clk(clk), .srst(srst), .standard_select(standard_select), .power_enable(power_enable),
    .hsync_in(hsync_in), .vsync_in(vsync_in), .combined_sync(combined_sync), .chip_active(chip_active),
    .timing(timing));
  vst_source src (.clk(clk), .hsync_in(hsync_in), .vsync_in(vsync_in), .colour_black(colour_black));

  // Sim rate stands in for the reference; counts use real rates
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) begin
    n_burst += timing.burst_flag;
    n_off += timing.offset_cancel;
    n_low += !combined_sync;
    n_ret += timing.retune_request;
    n_dirty += timing.clamp_window && !colour_black;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task automatic line(input int w, input logic comp);
    @(posedge clk);
    {n_burst, n_off, n_low, n_ret, n_dirty} = '0;
    src.pulse(w, comp);
    check("clamp black", n_dirty, 0);
  endtask : line

  task automatic t_ntsc(input logic comp);
    standard_select = 1'h1;
    v0 = timing.v_phase;
    line(58, comp);
    check("burst", n_burst, vst_pkg::NTSC_CLAMP_OFF - vst_pkg::NTSC_CLAMP_ON);
    check("vblank", timing.vblank_mode, 1'h0);
    check("offset", n_off, 2);
    check("low", n_low >= 56 && n_low <= 60, 1'h1);
    check("vphase", timing.v_phase, v0);
  endtask : t_ntsc
  task automatic t_bad(input int w);
    line(w, 1'h1);
    check("bad burst", n_burst, 0);
    check("bad vblank", timing.vblank_mode, 1'h1);
    check("retune", n_ret, 1);
  endtask : t_bad
  task automatic t_pal;
    standard_select = 1'h0;
    repeat (2) begin
      v0 = timing.v_phase;
      line(77, 1'h1);
      check("pal burst", n_burst, vst_pkg::PAL_CLAMP_OFF - vst_pkg::PAL_CLAMP_ON);
      check("pal vphase", timing.v_phase, !v0);
      check("pal offset", n_off, 2);
    end
  endtask : t_pal
  task automatic t_power;
    power_enable = 1'h0;
    line(58, 1'h1);
    check("active", chip_active, 1'h0);
    check("off windows", n_burst + n_off, 0);
    power_enable = 1'h1;
    line(77, 1'h1);
    check("resume", n_burst, vst_pkg::PAL_CLAMP_OFF - vst_pkg::PAL_CLAMP_ON);
  endtask : t_power

  initial begin
    {srst, standard_select, power_enable} = 3'h7;
    {bad_count, total_checks} = '0;
    repeat (12) @(negedge clk);
    srst = 1'h0;
    check("reset timing", timing, 6'h00);
    check("reset sync", combined_sync, 1'h1);
    t_ntsc(1'h1);
    t_ntsc(1'h0);
    t_bad(100);
    t_bad(30);
    t_pal;
    t_bad(50);
    t_power;
    final_report;
  end
  // Nine lines of about 270 cycles each; ample margin
  initial begin
    #100000;
    bad_count++;
    final_report;
  end
endmodule : vst_sync_timing_tb
